//--- hdl/telem_cmd_bank.sv
// Purpose: telemetry, identity and paged memory command bank
// Assumes: host commands arrive on mclk; mfg_test_mode is an async pin
// Notes: one command in flight; block reads stream one byte a cycle
// Functional notes
// - Current readback exponent is bits 10 to 6 of exponent config.
// - Readbacks carry 11-bit mantissa in bits 10 to 0.
// - Voltage readback exponent is sign-extended bits 2 to 0 of format register.
// - Power readback exponent is sign-extended bits 2 to 0 of exponent config.
// - Read-only byte reports protocol revision.
// - Three read-only bytes give maker id, model and revision.
// - Sixteen block codes map to memory pages 0 to 15.
// - Read-only byte returns download CRC.
// - Writable byte sets paged block read length.
// - Writable word sets start offset within the page.
// - Erase command erases a page only when memory is unlocked.
// - Pages 0 and 1 erase only in manufacturing test mode.
// - Correct key unlocks memory; when unlocked, a new value changes key.
// - Trim key written twice unlocks trim; other value relocks.
// - Maker data block command reads stored maker data.
`timescale 1ns/1ps
`default_nettype none
`include "telem_regs.svh"
module telem_cmd_bank
  import telem_pkg::*;
#(
  parameter logic [7:0] PROTO_REV = 8'h00,
  parameter logic [7:0] MAKER_ID = 8'h5e, // Arbitrary value
  parameter logic [7:0] MODEL_NO = 8'h3c, // Arbitrary value
  parameter logic [7:0] MAKER_REV = 8'h01 // Arbitrary value
)(
  input wire logic mclk, // Device clock, 25 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic cmd_valid, // Command request
  input wire logic cmd_write, // 1 write, 0 read
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [15:0] cmd_wdata, // Write data
  input wire logic [15:0] exp_cfg, // Exponent configuration register
  input wire logic [7:0] vout_format, // Output voltage format register
  input wire logic [10:0] iin_mant, // Input current mantissa
  input wire logic [10:0] vout_mant, // Output voltage mantissa
  input wire logic [10:0] pin_mant, // Input power mantissa
  input wire logic [7:0] dl_crc, // CRC of last download
  input wire logic mfg_test_mode, // Manufacturing test pin
  output logic cmd_ready, // Bank can take a command
  output logic cmd_ack, // Command finished, pulse
  output logic cmd_err, // Command refused, pulse
  output logic [15:0] rd_data, // Read answer
  output logic blk_valid, // Block byte valid, pulse
  output logic [7:0] blk_data, // Block byte
  output logic blk_last, // Last block byte, pulse
  output logic mem_unlocked, // Memory writes allowed
  output logic trim_unlocked // Trim registers writable
);

  telem_regs_t s_q;
  telem_regs_t s_d;
  logic take;
  logic is_page;
  logic is_blk;
  logic mem_we;
  logic er_en;
  logic er_ok;
  logic [7:0] mem_rd;
  logic [7:0] rd_addr;

  // Pack exponent and mantissa into one linear word
  function automatic logic [15:0] lin_word(input logic [4:0] e, input logic [10:0] m);
    lin_word = {e, m[10:8], m[7:0]};
  endfunction

  // Widen a three-bit twos-complement exponent
  function automatic logic [4:0] sext3(input logic [2:0] x);
    sext3 = {{2{x[2]}}, x};
  endfunction

  // Command decode shared by bank and store
  always_comb
  begin
    take = cmd_valid && (s_q.st == TELEM_ST_IDLE);
    is_page = (cmd_code >= `TELEM_CMD_PAGE0) && (cmd_code <= `TELEM_CMD_PAGE15);
    is_blk = is_page || (cmd_code == `TELEM_CMD_INFO);
    rd_addr = s_q.offs[7:0] + s_q.idx;
  end

  // Write and erase qualifiers; a locked store stays untouched
  always_comb
  begin
    mem_we = take && cmd_write && is_page && s_q.mem_unl;
    er_ok = (cmd_wdata[3:0] >= `TELEM_PROT_PAGES) || s_q.mfg_s2;
    er_en = take && cmd_write && (cmd_code == `TELEM_CMD_ERASE)
            && s_q.mem_unl && er_ok;
  end

  telem_page_store #(
    .PAGES(16),
    .PAGE_BYTES(256)
  ) u_store (
    .mclk(mclk),
    .wr_en(mem_we),
    .wr_page(cmd_code[3:0]),
    .wr_addr(s_q.offs[7:0]),
    .wr_data(cmd_wdata[7:0]),
    .er_en(er_en),
    .er_page(cmd_wdata[3:0]),
    .rd_page(s_q.page),
    .rd_addr(rd_addr),
    .rd_data(mem_rd)
  );

  // Next-state logic for the whole bank
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    s_d.blk_valid = 1'b0;
    s_d.blk_last = 1'b0;
    // Pin passes two flops before use
    s_d.mfg_s1 = mfg_test_mode;
    s_d.mfg_s2 = s_q.mfg_s1;
    unique case (s_q.st)
      TELEM_ST_IDLE:
      begin
        if (take)
        begin
          s_d.ack = 1'b1;
          s_d.rd_data = 16'h0000;
          case (cmd_code)
            `TELEM_CMD_IIN:
            begin
              s_d.err = cmd_write;
              s_d.rd_data = lin_word(exp_cfg[`TELEM_IIN_EXP_HI:`TELEM_IIN_EXP_LO],
                                     iin_mant);
            end
            `TELEM_CMD_VOUT:
            begin
              s_d.err = cmd_write;
              s_d.rd_data = lin_word(
                sext3(vout_format[`TELEM_VOUT_EXP_HI:`TELEM_VOUT_EXP_LO]),
                vout_mant);
            end
            `TELEM_CMD_PIN:
            begin
              s_d.err = cmd_write;
              s_d.rd_data = lin_word(sext3(exp_cfg[`TELEM_PIN_EXP_HI:`TELEM_PIN_EXP_LO]),
                                     pin_mant);
            end
            `TELEM_CMD_PREV:
            begin
              s_d.err = cmd_write;
              s_d.rd_data = {8'h00, PROTO_REV};
            end
            `TELEM_CMD_MID:
            begin
              s_d.err = cmd_write;
              s_d.rd_data = {8'h00, MAKER_ID};
            end
            `TELEM_CMD_MODEL:
            begin
              s_d.err = cmd_write;
              s_d.rd_data = {8'h00, MODEL_NO};
            end
            `TELEM_CMD_MREV:
            begin
              s_d.err = cmd_write;
              s_d.rd_data = {8'h00, MAKER_REV};
            end
            `TELEM_CMD_CRC:
            begin
              s_d.err = cmd_write;
              s_d.rd_data = {8'h00, dl_crc};
            end
            `TELEM_CMD_RDLEN:
            begin
              if (cmd_write)
              begin
                s_d.rd_len = cmd_wdata[7:0];
              end
              s_d.rd_data = {8'h00, s_q.rd_len};
            end
            `TELEM_CMD_OFFS:
            begin
              if (cmd_write)
              begin
                s_d.offs = cmd_wdata;
              end
              s_d.rd_data = s_q.offs;
            end
            `TELEM_CMD_ERASE:
            begin
              // Write only; refused erase is flagged to the host
              s_d.err = !cmd_write || !s_q.mem_unl || !er_ok;
            end
            `TELEM_CMD_MKEY:
            begin
              if (!cmd_write)
              begin
                s_d.err = 1'b1;
              end
              else if (cmd_wdata[7:0] == s_q.mkey)
              begin
                s_d.mem_unl = 1'b1;
              end
              else if (s_q.mem_unl)
              begin
                s_d.mkey = cmd_wdata[7:0];
              end
              else
              begin
                s_d.err = 1'b1;
              end
            end
            `TELEM_CMD_TKEY:
            begin
              if (!cmd_write)
              begin
                s_d.err = 1'b1;
              end
              else if (cmd_wdata[7:0] == `TELEM_TKEY_DEF)
              begin
                s_d.trim_armed = 1'b1;
                s_d.trim_unl = s_q.trim_armed;
              end
              else
              begin
                s_d.trim_armed = 1'b0;
                s_d.trim_unl = 1'b0;
              end
            end
            default:
            begin
              if (is_blk && cmd_write)
              begin
                // Maker data is read only; pages need the unlock
                s_d.err = !is_page || !s_q.mem_unl;
                if (is_page && s_q.mem_unl)
                begin
                  s_d.offs = s_q.offs + 16'h0001;
                end
              end
              else if (is_blk)
              begin
                s_d.page = is_page ? cmd_code[3:0] : `TELEM_INFO_PAGE;
                s_d.idx = 8'h00;
                s_d.left = s_q.rd_len;
                if (s_q.rd_len != 8'h00)
                begin
                  s_d.ack = 1'b0;
                  s_d.st = TELEM_ST_BLKRD;
                end
              end
              else
              begin
                s_d.err = 1'b1;
              end
            end
          endcase
        end
      end
      TELEM_ST_BLKRD:
      begin
        // One byte per cycle from offset plus index, wrapping in page
        s_d.blk_valid = 1'b1;
        s_d.blk_data = mem_rd;
        s_d.idx = s_q.idx + 8'h01;
        s_d.left = s_q.left - 8'h01;
        if (s_q.left == 8'h01)
        begin
          s_d.blk_last = 1'b1;
          s_d.ack = 1'b1;
          s_d.st = TELEM_ST_IDLE;
        end
      end
    endcase
    s_d.ready = (s_d.st == TELEM_ST_IDLE);
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.st <= TELEM_ST_IDLE;
      s_q.ready <= 1'b1;
      s_q.rd_len <= `TELEM_RDLEN_RST;
      s_q.offs <= `TELEM_OFFS_RST;
      s_q.mkey <= `TELEM_MKEY_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign cmd_ready = s_q.ready;
  assign cmd_ack = s_q.ack;
  assign cmd_err = s_q.err;
  assign rd_data = s_q.rd_data;
  assign blk_valid = s_q.blk_valid;
  assign blk_data = s_q.blk_data;
  assign blk_last = s_q.blk_last;
  assign mem_unlocked = s_q.mem_unl;
  assign trim_unlocked = s_q.trim_unl;

  // Checks on the bank's own behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_iin_exp_word: assert property (
    take && !cmd_write && cmd_code == `TELEM_CMD_IIN
    |=> cmd_ack && rd_data[15:11] == $past(exp_cfg[10:6]))
    else $error("current exponent wrong");
  a_iin_mant_bits: assert property (
    take && !cmd_write && cmd_code == `TELEM_CMD_IIN
    |=> rd_data[10:0] == $past(iin_mant))
    else $error("current mantissa wrong");
  a_vout_exp_ext: assert property (
    take && !cmd_write && cmd_code == `TELEM_CMD_VOUT
    |=> rd_data[15:11] == {{2{$past(vout_format[2])}}, $past(vout_format[2:0])})
    else $error("voltage exponent wrong");
  a_pin_exp_ext: assert property (
    take && !cmd_write && cmd_code == `TELEM_CMD_PIN
    |=> rd_data[15:11] == {{2{$past(exp_cfg[2])}}, $past(exp_cfg[2:0])})
    else $error("power exponent wrong");
  a_maker_id_byte: assert property (
    take && !cmd_write && cmd_code == `TELEM_CMD_MID
    |=> rd_data == {8'h00, MAKER_ID})
    else $error("maker id wrong");
  // First byte is registered one cycle after the store address settles
  a_blk_len_three: assert property (
    take && !cmd_write && is_blk && s_q.rd_len == 8'h03
    |=> !blk_valid ##1 blk_valid[*3] ##0 (blk_last && cmd_ack) ##1 !blk_valid)
    else $error("block length not honoured");
  a_erase_prot_pages: assert property (
    er_en |-> cmd_wdata[3:0] >= 4'h2 || s_q.mfg_s2)
    else $error("protected page erased");
  a_locked_no_write: assert property (
    !mem_unlocked && take && cmd_write && (is_page || cmd_code == `TELEM_CMD_ERASE)
    |=> cmd_ack && cmd_err)
    else $error("locked write not refused");
  a_mkey_unlock: assert property (
    take && cmd_write && cmd_code == `TELEM_CMD_MKEY
    && cmd_wdata[7:0] == s_q.mkey |=> mem_unlocked && !cmd_err)
    else $error("key did not unlock");
  a_trim_two_writes: assert property (
    $rose(trim_unlocked) |-> $past(s_q.trim_armed) && $past(cmd_code) == `TELEM_CMD_TKEY)
    else $error("trim unlocked too early");

  c_block_read: cover property (blk_valid ##1 blk_last);
  c_page_erase: cover property (er_en);
  c_trim_unlock: cover property ($rose(trim_unlocked));

endmodule
`default_nettype wire

//--- hdl/telem_regs.svh
// Purpose: command codes, field positions, reset values and timing counts
// Assumes: 8-bit command codes on the host command port
// Notes: included by bare name from the bank, page store and host model modules
`ifndef TELEM_REGS_SVH
`define TELEM_REGS_SVH

// Command codes
`define TELEM_CMD_IIN 8'h89
`define TELEM_CMD_VOUT 8'h8b
`define TELEM_CMD_PIN 8'h97
`define TELEM_CMD_PREV 8'h98
`define TELEM_CMD_MID 8'h99
`define TELEM_CMD_MODEL 8'h9a
`define TELEM_CMD_MREV 8'h9b
`define TELEM_CMD_PAGE0 8'hb0
`define TELEM_CMD_PAGE15 8'hbf
`define TELEM_CMD_CRC 8'hd1
`define TELEM_CMD_RDLEN 8'hd2
`define TELEM_CMD_OFFS 8'hd3
`define TELEM_CMD_ERASE 8'hd4
`define TELEM_CMD_MKEY 8'hd5
`define TELEM_CMD_TKEY 8'hd6
`define TELEM_CMD_INFO 8'hf1

// Exponent field positions in the exponent and output format registers
`define TELEM_IIN_EXP_HI 10
`define TELEM_IIN_EXP_LO 6
`define TELEM_PIN_EXP_HI 2
`define TELEM_PIN_EXP_LO 0
`define TELEM_VOUT_EXP_HI 2
`define TELEM_VOUT_EXP_LO 0

// Reset and fixed values
`define TELEM_RDLEN_RST 8'h20
`define TELEM_OFFS_RST 16'h0000
`define TELEM_MKEY_RST 8'hff
`define TELEM_TKEY_DEF 8'h00
`define TELEM_ERASED 8'hff
`define TELEM_PROT_PAGES 4'h2
`define TELEM_INFO_PAGE 4'h0

// Host spacing after an erase, kept for the bench
`define TELEM_ERASE_WAIT_MS 35

`endif

//--- hdl/telem_pkg.sv
// Purpose: types shared by the command bank and its page store
// Assumes: constants live in telem_regs.svh
// Notes: the command bank's state is one packed struct; the page store keeps a plain byte array
package telem_pkg;

  typedef enum logic [1:0] {
    TELEM_ST_IDLE = 2'b01,
    TELEM_ST_BLKRD = 2'b10
  } telem_state_t;

  typedef struct packed {
    telem_state_t st;
    logic ready;
    logic ack;
    logic err;
    logic [15:0] rd_data;
    logic blk_valid;
    logic blk_last;
    logic [7:0] blk_data;
    logic [3:0] page;
    logic [7:0] idx;
    logic [7:0] left;
    logic [7:0] rd_len;
    logic [15:0] offs;
    logic [7:0] mkey;
    logic mem_unl;
    logic trim_armed;
    logic trim_unl;
    logic mfg_s1;
    logic mfg_s2;
  } telem_regs_t;

endpackage

//--- hdl/telem_page_store.sv
// Purpose: sixteen-page byte store behind the paged block commands
// Assumes: writes and erases already qualified by the command bank
// Notes: asynchronous read so the bank can register the byte itself
`timescale 1ns/1ps
`default_nettype none
`include "telem_regs.svh"
module telem_page_store
  import telem_pkg::*;
#(
  parameter int PAGES = 16,
  parameter int PAGE_BYTES = 256
)(
  input wire logic mclk, // Device clock
  input wire logic wr_en, // Byte write strobe
  input wire logic [3:0] wr_page, // Page for the write
  input wire logic [7:0] wr_addr, // Byte within the page
  input wire logic [7:0] wr_data, // Byte to store
  input wire logic er_en, // Page erase strobe
  input wire logic [3:0] er_page, // Page to erase
  input wire logic [3:0] rd_page, // Page for the read
  input wire logic [7:0] rd_addr, // Byte within the page
  output logic [7:0] rd_data // Byte read, combinational
);

  logic [7:0] mem [PAGES][PAGE_BYTES];

  // Storage has no reset; erase is the only bulk clear
  always_ff @(posedge mclk)
  begin
    if (er_en)
    begin
      for (int b = 0; b < PAGE_BYTES; b++)
      begin
        mem[er_page][b] <= `TELEM_ERASED;
      end
    end
    else if (wr_en)
    begin
      mem[wr_page][wr_addr] <= wr_data;
    end
  end

  // Read of the addressed byte
  always_comb
  begin
    rd_data = mem[rd_page][rd_addr];
  end

endmodule
`default_nettype wire

//--- testbench/telem_host_model.sv
// Purpose: host-side model issuing one bank command at a time
// Assumes: commands driven 1 ns after mclk rises, bank contract as handed over
// Notes: erase spacing is shortened through ERASE_WAIT to keep runs short
`timescale 1ns/1ps
`default_nettype none
`include "telem_regs.svh"
module telem_host_model #(
  parameter int ERASE_WAIT = 40
)(
  input wire logic mclk, // Device clock
  input wire logic cmd_ready, // Bank idle
  input wire logic cmd_ack, // Command done
  input wire logic cmd_err, // Command refused
  input wire logic [15:0] rd_data, // Read answer
  input wire logic blk_valid, // Block byte valid
  input wire logic [7:0] blk_data, // Block byte
  output logic cmd_valid, // Request
  output logic cmd_write, // Write when high
  output logic [7:0] cmd_code, // Command code
  output logic [15:0] cmd_wdata // Write data
);
  logic [7:0] blk_q[$];

  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // One command; ok stays low when a bound runs out
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    rd = 16'h0000;
    err = 1'b0;
    blk_q.delete();
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wd;
    // Request held until an edge that sees ready high
    while (!cmd_ready && n < 100)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 100)
      return;
    @(posedge mclk);
    #1;
    // Released lines do not keep their last value
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~wd;
    // The ack of a plain command already stands right after the take edge
    for (n = 0; n < 600 && !ok; n++)
    begin
      if (blk_valid)
        blk_q.push_back(blk_data);
      if (cmd_ack)
      begin
        ok = 1'b1;
        rd = rd_data;
        err = cmd_err;
      end
      else
      begin
        @(posedge mclk);
        #1;
      end
    end
    if (ok && wr && code == `TELEM_CMD_ERASE)
      repeat (ERASE_WAIT) @(posedge mclk);
    // One idle edge so the next request never reuses this time step
    @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

//--- testbench/telem_cmd_bank_tb.sv
// Purpose: self-checking bench for the telemetry and memory command bank
// Assumes: host model owns the command port, bench owns measurement inputs
// Notes: page store survives a mid-run reset, used for the locked checks
`timescale 1ns/1ps
`default_nettype none
module telem_cmd_bank_tb
  import telem_pkg::*;
;
  localparam logic [7:0] PREV = 8'h12; // Arbitrary value
  localparam logic [7:0] MID = 8'ha7; // Arbitrary value
  localparam logic [7:0] MODEL = 8'h4d; // Arbitrary value
  localparam logic [7:0] MREV = 8'h06; // Arbitrary value
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_write, cmd_ready, cmd_ack, cmd_err, blk_valid, blk_last;
  logic [7:0] cmd_code, blk_data;
  logic [15:0] cmd_wdata, rd_data;
  logic [15:0] exp_cfg = 16'h07c5;
  logic [7:0] vout_format = 8'h03;
  logic [10:0] iin_mant = 11'h5a3;
  logic [10:0] vout_mant = 11'h2c1;
  logic [10:0] pin_mant = 11'h7ff;
  logic [7:0] dl_crc = 8'h9e;
  logic mfg_test_mode = 1'b0;
  logic mem_unlocked, trim_unlocked;
  int error_cnt = 0;
  int tests_run = 0;

  always #20 mclk = ~mclk;

  telem_cmd_bank #(.PROTO_REV(PREV), .MAKER_ID(MID), .MODEL_NO(MODEL), .MAKER_REV(MREV)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .exp_cfg(exp_cfg), .vout_format(vout_format),
    .iin_mant(iin_mant), .vout_mant(vout_mant), .pin_mant(pin_mant), .dl_crc(dl_crc),
    .mfg_test_mode(mfg_test_mode), .cmd_ready(cmd_ready), .cmd_ack(cmd_ack), .cmd_err(cmd_err),
    .rd_data(rd_data), .blk_valid(blk_valid), .blk_data(blk_data), .blk_last(blk_last),
    .mem_unlocked(mem_unlocked), .trim_unlocked(trim_unlocked));

  telem_host_model i_host (
    .mclk(mclk), .cmd_ready(cmd_ready), .cmd_ack(cmd_ack), .cmd_err(cmd_err),
    .rd_data(rd_data), .blk_valid(blk_valid), .blk_data(blk_data), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  task automatic summarize;
    $display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A lost answer ends the run at once
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                     output logic [15:0] r, output logic e);
    logic ok;
    i_host.xfer(wr, code, wd, r, e, ok);
    if (!ok)
    begin
      error_cnt++;
      $display("mismatch answer to %h expected ack seen none", code);
      summarize();
    end
  endtask

  task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] r;
    logic e;
    cmd(1'b0, code, 16'h0000, r, e);
    check("read data", r, exp);
    check("read refusal", {15'h0000, e}, 16'h0000);
  endtask

  task automatic wrchk(input logic [7:0] code, input logic [15:0] d, input logic experr);
    logic [15:0] r;
    logic e;
    cmd(1'b1, code, d, r, e);
    check("write refusal", {15'h0000, e}, {15'h0000, experr});
  endtask

  // Block read from offset 0x01fe; erased pages expect 0xff
  task automatic blkrd(input logic [7:0] code, input int len, input logic [7:0] base,
                       input logic erased);
    logic [15:0] r;
    logic e;
    wrchk(8'hd3, 16'h01fe, 1'b0);
    wrchk(8'hd2, len[15:0], 1'b0);
    cmd(1'b0, code, 16'h0000, r, e);
    check("block count", 16'(i_host.blk_q.size()), len[15:0]);
    for (int i = 0; i < i_host.blk_q.size(); i++)
      check("block byte", {8'h00, i_host.blk_q[i]}, erased ? 16'h00ff : 16'(base + i));
  endtask

  task automatic do_reset;
    rst_n = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    check("ready after reset", {15'h0000, cmd_ready}, 16'h0001);
    check("locks after reset", {14'h0000, mem_unlocked, trim_unlocked}, 16'h0000);
    rdchk(8'hd2, 16'h0020);
    rdchk(8'hd3, 16'h0000);
    $display("test reset done");
  endtask

  // Two exponent settings, one negative and one positive per field
  task automatic t_telem;
    for (int k = 0; k < 2; k++)
    begin
      rdchk(8'h89, {exp_cfg[10:6], iin_mant});
      rdchk(8'h8b, {{2{vout_format[2]}}, vout_format[2:0], vout_mant});
      rdchk(8'h97, {{2{exp_cfg[2]}}, exp_cfg[2:0], pin_mant});
      exp_cfg = 16'hf842;
      vout_format = 8'hfc;
      pin_mant = 11'h001;
    end
    $display("test telemetry done");
  endtask

  task automatic t_ids;
    rdchk(8'h98, {8'h00, PREV});
    rdchk(8'h99, {8'h00, MID});
    rdchk(8'h9a, {8'h00, MODEL});
    rdchk(8'h9b, {8'h00, MREV});
    rdchk(8'hd1, {8'h00, dl_crc});
    wrchk(8'h99, 16'h0011, 1'b1);
    wrchk(8'h98, 16'h0011, 1'b1);
    $display("test identity done");
  endtask

  // Wrong key refused, reset key unlocks
  task automatic t_key;
    wrchk(8'hd5, 16'h0012, 1'b1);
    check("locked", {15'h0000, mem_unlocked}, 16'h0000);
    wrchk(8'hd5, 16'h00ff, 1'b0);
    check("unlocked", {15'h0000, mem_unlocked}, 16'h0001);
    $display("test key done");
  endtask

  // Three bytes per page across the 0xff to 0x00 address wrap
  task automatic t_pages;
    for (int p = 0; p < 16; p++)
    begin
      wrchk(8'hd3, 16'h01fe, 1'b0);
      for (int k = 0; k < 3; k++)
        wrchk(8'hb0 + 8'(p), {8'h00, 4'(p), 4'(k)}, 1'b0);
      rdchk(8'hd3, 16'h0201);
    end
    for (int p = 0; p < 16; p++)
      blkrd(8'hb0 + 8'(p), 3, {4'(p), 4'h0}, 1'b0);
    blkrd(8'hf1, 2, 8'h00, 1'b0);
    blkrd(8'hb2, 0, 8'h20, 1'b0);
    $display("test pages done");
  endtask

  task automatic t_erase;
    wrchk(8'hd4, 16'h0005, 1'b0);
    blkrd(8'hb5, 3, 8'h50, 1'b1);
    wrchk(8'hd4, 16'h0001, 1'b1);
    wrchk(8'hd4, 16'h0000, 1'b1);
    blkrd(8'hb1, 3, 8'h10, 1'b0);
    blkrd(8'hb0, 3, 8'h00, 1'b0);
    mfg_test_mode = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    wrchk(8'hd4, 16'h0001, 1'b0);
    blkrd(8'hb1, 3, 8'h10, 1'b1);
    mfg_test_mode = 1'b0;
    $display("test erase done");
  endtask

  // After a second reset the store is locked again but keeps its bytes
  task automatic t_locked;
    do_reset();
    wrchk(8'hd3, 16'h00fe, 1'b0);
    wrchk(8'hb2, 16'h00aa, 1'b1);
    wrchk(8'hd4, 16'h0002, 1'b1);
    wrchk(8'hd5, 16'h00ff, 1'b0);
    blkrd(8'hb2, 3, 8'h20, 1'b0);
    $display("test locked done");
  endtask

  task automatic t_trim;
    logic [15:0] r;
    logic e;
    wrchk(8'hd6, 16'h0000, 1'b0);
    check("trim once", {15'h0000, trim_unlocked}, 16'h0000);
    rdchk(8'h98, {8'h00, PREV});
    wrchk(8'hd6, 16'h0000, 1'b0);
    check("trim twice", {15'h0000, trim_unlocked}, 16'h0001);
    wrchk(8'hd6, 16'h0007, 1'b0);
    check("trim relock", {15'h0000, trim_unlocked}, 16'h0000);
    // Key register is write only, so a read is refused
    cmd(1'b0, 8'hd6, 16'h0000, r, e);
    check("trim key read data", r, 16'h0000);
    check("trim key read refusal", {15'h0000, e}, 16'h0001);
    $display("test trim done");
  endtask

  initial
  begin
    do_reset();
    t_telem();
    t_ids();
    t_key();
    t_pages();
    t_erase();
    t_locked();
    t_trim();
    summarize();
  end
endmodule
`default_nettype wire
